/* File: inc/rsas_pkg.sv */
// package for the radio start register and area select block
// assumes an 8-bit classic wishbone port with 12-bit byte addresses
package rsas_pkg;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] START_CTRL_ADDR = 12'h000;
  localparam logic [11:0] WINDOW_BASE = 12'h600;
  localparam logic [11:0] RAM_BASE = 12'h800;
  localparam int RAM_ADDR_W = 11;
  localparam int RAM_DEPTH = 2048;

  // ----------------------------------------
  // start register fields and reset value
  // ----------------------------------------
  localparam int RADIO_BIT = 0;
  localparam int CALIB_BIT = 2;
  localparam int SELECT_BIT = 3;
  localparam int SLEEP_BIT = 5;
  localparam logic [7:0] START_CTRL_RESET = 8'h01;

  typedef struct packed {
    logic sleep_transition_permit;
    logic window_area_select;
    logic calibration_permit;
    logic radio_function_enable;
  } rsas_ctrl_s;

  localparam rsas_ctrl_s CTRL_RESET = '{
    sleep_transition_permit: START_CTRL_RESET[SLEEP_BIT],
    window_area_select: START_CTRL_RESET[SELECT_BIT],
    calibration_permit: START_CTRL_RESET[CALIB_BIT],
    radio_function_enable: START_CTRL_RESET[RADIO_BIT]
  };

  // ----------------------------------------
  // bus answer sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_FETCH,
    BUS_ACK
  } rsas_bus_e;

endpackage

/* File: rtl/rsas_ram.sv */
// single port write, registered read byte memory
// assumes both ports on the block clock; contents not reset
`timescale 1ns/10ps
`default_nettype none

module rsas_ram #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 2048,
  parameter int ADDR_W = 11
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // only the read register is reset; the array stays unreset for area
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

`default_nettype wire

/* File: rtl/rsas_top.sv */
// start register, window area decode and shared tx/rx ram
// assumes an 8-bit classic wishbone master and a radio datapath on clk_in
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R01: the radio function runs while bit 0 of the start register is 1 and is off while it is 0.
// R02: calibration is permitted while bit 2 is 1 and kept disabled while it is 0.
// R03: software writes bit 2 back to 0 once calibration has finished.
// R04: bit 3 chooses what decodes at 0600H to 0FFFH, leaving lower addresses alone.
// R05: an IDLE to STANDBY move happens only while bit 5 is 1, which software sets to ask for it.
// R06: the start register resets to 01H and bits 7, 6, 4 and 1 always read 0.
// R07: with bit 3 set, a 2-Kbyte ram sits in the window and writes there store into transmit ram.
// R08: reads in that ram window return receive ram, not the transmit data written there.
// R09: 0000H to 05FFH is always the unbanked area, and with bit 3 clear the window is bank 0.
module rsas_top
  import rsas_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic wb_sel_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [DATA_W-1:0] wb_dat_in,
  output logic [DATA_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // radio datapath side
  input wire logic idle_state_in,
  input wire logic rx_wr_en_in,
  input wire logic [RAM_ADDR_W-1:0] rx_wr_addr_in,
  input wire logic [DATA_W-1:0] rx_wr_data_in,
  input wire logic [RAM_ADDR_W-1:0] tx_rd_addr_in,
  output logic [DATA_W-1:0] tx_rd_data_out,
  // control outputs
  output logic radio_function_enable_out,
  output logic calibration_permit_out,
  output logic window_area_select_out,
  output logic standby_enter_out
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  rsas_bus_e bus_q, bus_d;
  rsas_ctrl_s ctrl_q, ctrl_d;
  logic [DATA_W-1:0] dat_q, dat_d;
  logic ack_q, ack_d;
  logic standby_q, standby_d;
  logic rd_ram_q, rd_ram_d;
  logic rd_ctrl_q, rd_ctrl_d;
  logic take, hit_ctrl, hit_ram, tx_we;
  logic [DATA_W-1:0] rx_q, ctrl_rd;

  // one access at a time; a new take waits for the bus to fall idle
  assign take = wb_cyc_in && wb_stb_in && (bus_q == BUS_IDLE) && !ack_q;
  assign hit_ctrl = (wb_adr_in == START_CTRL_ADDR);
  assign hit_ram = ctrl_q.window_area_select && (wb_adr_in >= RAM_BASE); // R04 R09
  assign tx_we = take && wb_we_in && wb_sel_in && hit_ram; // R07

  always_comb begin
    ctrl_rd = '0; // R06
    ctrl_rd[RADIO_BIT] = ctrl_q.radio_function_enable;
    ctrl_rd[CALIB_BIT] = ctrl_q.calibration_permit;
    ctrl_rd[SELECT_BIT] = ctrl_q.window_area_select;
    ctrl_rd[SLEEP_BIT] = ctrl_q.sleep_transition_permit;
  end

  // ----------------------------------------
  // shared ram pair
  // ----------------------------------------
  // transmit ram: bus writes, radio reads
  rsas_ram #(.DATA_W(DATA_W), .DEPTH(RAM_DEPTH), .ADDR_W(RAM_ADDR_W)) u_tx_ram (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(tx_we),
    .wr_addr_in(wb_adr_in[RAM_ADDR_W-1:0]),
    .wr_data_in(wb_dat_in),
    .rd_addr_in(tx_rd_addr_in),
    .rd_data_out(tx_rd_data_out)
  );

  // receive ram: radio writes, bus reads
  rsas_ram #(.DATA_W(DATA_W), .DEPTH(RAM_DEPTH), .ADDR_W(RAM_ADDR_W)) u_rx_ram (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(rx_wr_en_in),
    .wr_addr_in(rx_wr_addr_in),
    .wr_data_in(rx_wr_data_in),
    .rd_addr_in(wb_adr_in[RAM_ADDR_W-1:0]),
    .rd_data_out(rx_q)
  );

  // ----------------------------------------
  // register and answer logic
  // ----------------------------------------
  always_comb begin
    bus_d = bus_q;
    ctrl_d = ctrl_q;
    dat_d = dat_q;
    ack_d = 1'b0;
    rd_ram_d = rd_ram_q;
    rd_ctrl_d = rd_ctrl_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (take) begin
          bus_d = BUS_FETCH;
          rd_ram_d = hit_ram;
          rd_ctrl_d = hit_ctrl;
          if (wb_we_in && wb_sel_in && hit_ctrl) begin
            ctrl_d.radio_function_enable = wb_dat_in[RADIO_BIT]; // R01
            ctrl_d.calibration_permit = wb_dat_in[CALIB_BIT]; // R02
            ctrl_d.window_area_select = wb_dat_in[SELECT_BIT]; // R04
            ctrl_d.sleep_transition_permit = wb_dat_in[SLEEP_BIT]; // R05
          end
        end
      end
      BUS_FETCH: begin
        // extra cycle lets the ram read settle so data leaves a flop
        bus_d = BUS_ACK;
        ack_d = 1'b1;
        if (rd_ram_q) begin
          dat_d = rx_q; // R08
        end else if (rd_ctrl_q) begin
          dat_d = ctrl_rd; // R06
        end else begin
          dat_d = '0; // R09
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      // the fourth code of the two-bit state is unused; fall back to idle
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // standby move is a level that follows the permit and the idle state
  assign standby_d = ctrl_q.sleep_transition_permit && idle_state_in; // R05

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_q <= BUS_IDLE;
      ctrl_q <= CTRL_RESET; // R06
      dat_q <= '0;
      ack_q <= 1'b0;
      standby_q <= 1'b0;
      rd_ram_q <= 1'b0;
      rd_ctrl_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      ctrl_q <= ctrl_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
      standby_q <= standby_d;
      rd_ram_q <= rd_ram_d;
      rd_ctrl_q <= rd_ctrl_d;
    end
  end

  assign wb_dat_out = dat_q;
  assign wb_ack_out = ack_q;
  assign radio_function_enable_out = ctrl_q.radio_function_enable;
  assign calibration_permit_out = ctrl_q.calibration_permit;
  assign window_area_select_out = ctrl_q.window_area_select;
  assign standby_enter_out = standby_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_ctrl_write;
    take && wb_we_in && wb_sel_in && hit_ctrl;
  endsequence

  sequence s_ram_read;
    take && !wb_we_in && hit_ram;
  endsequence

  sequence s_low_read;
    take && !wb_we_in && !hit_ctrl && (wb_adr_in < WINDOW_BASE);
  endsequence

  a_radio_enable_write: assert property ( // R01
    @(posedge clk_in) disable iff (!reset_n_in)
    s_ctrl_write |=> radio_function_enable_out == $past(wb_dat_in[RADIO_BIT]))
    else $error("radio enable did not follow the written bit");

  a_calib_permit_write: assert property ( // R02
    @(posedge clk_in) disable iff (!reset_n_in)
    s_ctrl_write |=> calibration_permit_out == $past(wb_dat_in[CALIB_BIT]))
    else $error("calibration permit did not follow the written bit");

  a_window_select_write: assert property ( // R04
    @(posedge clk_in) disable iff (!reset_n_in)
    s_ctrl_write |=> window_area_select_out == $past(wb_dat_in[SELECT_BIT]))
    else $error("window select did not follow the written bit");

  a_standby_gate: assert property ( // R05
    @(posedge clk_in) disable iff (!reset_n_in)
    standby_enter_out |-> $past(ctrl_q.sleep_transition_permit) && $past(idle_state_in))
    else $error("standby entered without permission while idle");

  a_ctrl_read_zero: assert property ( // R06
    @(posedge clk_in) disable iff (!reset_n_in)
    (take && !wb_we_in && hit_ctrl) |-> ##2 (wb_ack_out && wb_dat_out[7:6] == 2'h0
      && !wb_dat_out[4] && !wb_dat_out[1]))
    else $error("start register reserved bits read nonzero");

  a_tx_write_route: assert property ( // R07
    @(posedge clk_in) disable iff (!reset_n_in)
    tx_we |-> window_area_select_out && wb_adr_in >= RAM_BASE && wb_we_in)
    else $error("transmit ram written outside the memory view");

  a_rx_read_back: assert property ( // R08
    @(posedge clk_in) disable iff (!reset_n_in)
    s_ram_read |=> ##1 (wb_ack_out && wb_dat_out == $past(rx_q)))
    else $error("ram window read did not return receive ram");

  a_low_area_zero: assert property ( // R09
    @(posedge clk_in) disable iff (!reset_n_in)
    s_low_read |-> ##2 (wb_ack_out && wb_dat_out == 8'h00))
    else $error("unbanked area read returned nonzero");

  a_ack_single: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    wb_ack_out |=> !wb_ack_out ##1 !wb_ack_out)
    else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

/* File: testbench/tb_rsas_top.sv */
// self-checking bench for the start register, window decode and tx/rx ram
// assumes rsas_top answers classic wishbone requests with a registered ack
`timescale 1ns/10ps
`default_nettype none

module tb_rsas_top;
  import rsas_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sel = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0;
  logic [DATA_W-1:0] rdat;
  logic ack;
  logic idle = 1'b0;
  logic rx_en = 1'b0;
  logic [RAM_ADDR_W-1:0] rx_adr = '0;
  logic [DATA_W-1:0] rx_dat = '0;
  logic [RAM_ADDR_W-1:0] tx_adr = '0;
  logic [DATA_W-1:0] tx_dat;
  logic radio;
  logic calib;
  logic area;
  logic standby;
  logic [DATA_W-1:0] got;
  int miscompares = 0;
  int total_checks = 0;

  rsas_top i_dut (
    .clk_in(clk),
    .reset_n_in(reset_n),
    .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_we_in(we),
    .wb_sel_in(sel),
    .wb_adr_in(adr),
    .wb_dat_in(wdat),
    .wb_dat_out(rdat),
    .wb_ack_out(ack),
    .idle_state_in(idle),
    .rx_wr_en_in(rx_en),
    .rx_wr_addr_in(rx_adr),
    .rx_wr_data_in(rx_dat),
    .tx_rd_addr_in(tx_adr),
    .tx_rd_data_out(tx_dat),
    .radio_function_enable_out(radio),
    .calibration_permit_out(calib),
    .window_area_select_out(area),
    .standby_enter_out(standby)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 1'b1;
    adr <= a;
    wdat <= d;
    // ack is expected on the third clock after the request (checked below); the watchdog ends a stuck wait
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    got = rdat;
    chk("ack latency", 8'h03, n[7:0]);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [11:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, exp, got);
  endtask

  task automatic outs(input logic [3:0] exp);
    @(negedge clk);
    chk("ctrl outs", {4'h0, exp}, {4'h0, radio, calib, area, standby});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    outs(4'b1000);
    rd("start reset", START_CTRL_ADDR, 8'h01);
    // idle without permission must not raise the standby move
    @(posedge clk);
    idle <= 1'b1;
    repeat (2) @(posedge clk);
    outs(4'b1000);
    @(posedge clk);
    idle <= 1'b0;
    bus(1'b1, START_CTRL_ADDR, 8'hff);
    rd("start fixed zeros", START_CTRL_ADDR, 8'h2d);
    outs(4'b1110);
    @(posedge clk);
    idle <= 1'b1;
    repeat (2) @(posedge clk);
    outs(4'b1111);
    @(posedge clk);
    idle <= 1'b0;
    repeat (2) @(posedge clk);
    outs(4'b1110);
    bus(1'b1, 12'h805, 8'ha5);
    @(posedge clk);
    tx_adr <= 11'h005;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("tx ram", 8'ha5, tx_dat);
    @(posedge clk);
    rx_en <= 1'b1;
    rx_adr <= 11'h005;
    rx_dat <= 8'h3c;
    @(posedge clk);
    rx_en <= 1'b0;
    rd("rx ram", 12'h805, 8'h3c);
    rd("bank 1", 12'h600, 8'h00);
    rd("unbanked", 12'h001, 8'h00);
    bus(1'b1, START_CTRL_ADDR, 8'h20);
    outs(4'b0000);
    rd("bank 0", 12'h805, 8'h00);
    bus(1'b1, 12'h805, 8'h11);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("tx kept", 8'ha5, tx_dat);
    rd("start low", START_CTRL_ADDR, 8'h20);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd("start rereset", START_CTRL_ADDR, 8'h01);
    finish_test;
  end

endmodule
`default_nettype wire
